// File: rtl/ouh_defs.svh
// Purpose: constants of the octal uart host front end
// Assumes: included by its bare name
// Notes: offsets in the config space are low seven address bits
`ifndef OUH_DEFS_SVH
`define OUH_DEFS_SVH

// ---------------------------------------------------------------
// geometry and channel register offsets
// ---------------------------------------------------------------
`define OUH_NCH 8
`define OUH_CH_MCR 4'h4
`define OUH_CH_MSR 4'h6
`define OUH_CH_FEATURE_CONTROL_REG 4'h8
`define OUH_REG_RST_VAL 8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define OUH_MCR_DTR_BIT 0
`define OUH_MCR_RTS_BIT 1
`define OUH_MCR_IR_BIT 6
`define OUH_FEATURE_CONTROL_REG_IRINV_BIT 4
`define OUH_MSR_CTS_BIT 4
`define OUH_MSR_DSR_BIT 5
`define OUH_MSR_RI_BIT 6
`define OUH_MSR_CD_BIT 7
`define OUH_BCAST_BIT 0
`define OUH_TMR_EN_BIT 0
`define OUH_TMR_EXT_BIT 1
`define OUH_INT1_TMR_BIT 0
`define OUH_INT1_WAKE_BIT 1

// ---------------------------------------------------------------
// config space offsets
// ---------------------------------------------------------------
`define OUH_CFG_INT0 7'h00
`define OUH_CFG_INT1 7'h01
`define OUH_CFG_INT2 7'h02
`define OUH_CFG_INT3 7'h03
`define OUH_CFG_TMR_CTRL 7'h04
`define OUH_CFG_TMR_LSB 7'h06
`define OUH_CFG_TMR_MSB 7'h07
`define OUH_CFG_SWRST 7'h0a
`define OUH_CFG_BCAST 7'h0f

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define OUH_CLK_NS 20
`define OUH_HWRST_MIN_NS 40
`define OUH_HWRST_CYC ((`OUH_HWRST_MIN_NS + `OUH_CLK_NS - 1) / `OUH_CLK_NS)

`endif

// File: rtl/ouh_pkg.sv
// Purpose: shared types of the octal uart host front end
// Assumes: nothing
// Notes: constants live in ouh_defs.svh
package ouh_pkg;
    typedef logic [7:0] ouh_byte_t;
    typedef logic [2:0] ouh_chan_t;
    // host access phase, one-hot
    typedef enum logic [2:0] {
        OUH_ACC_IDLE = 3'b001,
        OUH_ACC_RD = 3'b010,
        OUH_ACC_WR = 3'b100
    } ouh_acc_t;
endpackage

// File: rtl/ouh_chan_regs.sv
// Purpose: one uart channel register set with modem pins and rx front end
// Assumes: inputs synchronous to clk
// Notes: msr reads live pin levels, inverted to active high
`include "ouh_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module ouh_chan_regs (
    // clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic soft_rst,
    input wire logic infrared_startup_strap,
    // register access
    input wire logic wr_en,
    input wire logic [3:0] addr,
    input wire ouh_pkg::ouh_byte_t wdata,
    output ouh_pkg::ouh_byte_t rd_data,
    // serial and modem pins
    input wire logic serial_receive_in,
    input wire logic clear_send_in_n,
    input wire logic set_ready_in_n,
    input wire logic carrier_detect_in_n,
    input wire logic ring_indicate_in_n,
    output logic request_send_out_n,
    output logic terminal_ready_out_n,
    output logic ir_decoder_in_r,
    output logic rx_idle_r
);
    import ouh_pkg::*;

    ouh_byte_t regs_r [16];
    ouh_byte_t msr;
    logic ir_mode;
    logic ir_inv;

    // ---------------------------------------------------------------
    // register storage
    // ---------------------------------------------------------------
    // reset wins over a write in the same cycle; strap lands in ir bit
    always_ff @(posedge clk) begin
        if (rst || soft_rst) begin
            for (int i = 0; i < 16; i++) begin
                regs_r[i] <= `OUH_REG_RST_VAL;
            end
            regs_r[`OUH_CH_MCR][`OUH_MCR_IR_BIT] <= infrared_startup_strap;
        end else if (wr_en) begin
            regs_r[addr] <= wdata;
        end
    end

    assign ir_mode = regs_r[`OUH_CH_MCR][`OUH_MCR_IR_BIT];
    assign ir_inv = regs_r[`OUH_CH_FEATURE_CONTROL_REG][`OUH_FEATURE_CONTROL_REG_IRINV_BIT];

    // modem outputs, active low from mcr bits
    assign request_send_out_n = ~regs_r[`OUH_CH_MCR][`OUH_MCR_RTS_BIT];
    assign terminal_ready_out_n = ~regs_r[`OUH_CH_MCR][`OUH_MCR_DTR_BIT];

    // status inputs, active low on the pin
    always_comb begin
        msr = 8'h00;
        msr[`OUH_MSR_CTS_BIT] = ~clear_send_in_n;
        msr[`OUH_MSR_DSR_BIT] = ~set_ready_in_n;
        msr[`OUH_MSR_RI_BIT] = ~ring_indicate_in_n;
        msr[`OUH_MSR_CD_BIT] = ~carrier_detect_in_n;
    end

    assign rd_data = (addr == `OUH_CH_MSR) ? msr : regs_r[addr];

    // ---------------------------------------------------------------
    // receive front end
    // ---------------------------------------------------------------
    // inversion only in infrared mode; plain rxd idles high
    always_ff @(posedge clk) begin
        if (rst) begin
            ir_decoder_in_r <= 1'b1;
            rx_idle_r <= 1'b1;
        end else begin
            ir_decoder_in_r <= (ir_mode && ir_inv) ? ~serial_receive_in : serial_receive_in;
            rx_idle_r <= !ir_mode && serial_receive_in;
        end
    end

    ir_invert_a: assert property (@(posedge clk) disable iff (rst)
        ir_mode && ir_inv && !soft_rst |=> ir_decoder_in_r == !$past(serial_receive_in))
        else $error("ir receive not inverted");
    strap_copy_a: assert property (@(posedge clk) disable iff (rst)
        soft_rst |=> ir_mode == $past(infrared_startup_strap))
        else $error("strap not copied to mcr");
    rts_level_a: assert property (@(posedge clk) disable iff (rst)
        wr_en && !soft_rst && addr == `OUH_CH_MCR |=> request_send_out_n == !$past(wdata[`OUH_MCR_RTS_BIT]))
        else $error("rts pin not active low");
endmodule // ouh_chan_regs
`default_nettype wire

// File: rtl/ouh_top.sv
// Purpose: host port front end of an eight channel uart device
// Assumes: all inputs synchronous to clk (oscillator clock)
// Notes: fifo, baud, tx, rx cores and interrupt pin live elsewhere
`include "ouh_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module ouh_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic hw_reset_in_n,
    // straps
    input wire logic bus_style_strap,
    input wire logic infrared_startup_strap,
    // host bus
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] addr,
    input wire ouh_pkg::ouh_byte_t data_in,
    output ouh_pkg::ouh_byte_t data_out_r,
    output logic data_out_en_n,
    // interrupt sources and timer clock
    input wire logic [7:0] chan_irq_in,
    input wire logic wake_in,
    input wire logic timer_ext_clock,
    // serial pins, one bit per channel
    input wire logic [7:0] serial_receive_in,
    input wire logic [7:0] clear_send_in_n,
    input wire logic [7:0] set_ready_in_n,
    input wire logic [7:0] carrier_detect_in_n,
    input wire logic [7:0] ring_indicate_in_n,
    output logic [7:0] request_send_out_n,
    output logic [7:0] terminal_ready_out_n,
    output logic [7:0] ir_decoder_in_r,
    output logic [7:0] rx_idle_r
);
    import ouh_pkg::*;

    ouh_acc_t acc_r, acc_nxt;
    logic [1:0] hw_low_cnt_r;
    logic hw_rst, core_rst;
    logic rd_act, wr_act, wr_pulse, rd_pulse, cfg_sel;
    ouh_chan_t chan_sel;
    logic [7:0] chan_we;
    logic [7:0] soft_rst_r;
    ouh_byte_t bcast_r, tmr_ctrl_r, tmr_lsb_r, tmr_msb_r, cfg_rd, int1;
    ouh_byte_t chan_rd [8];
    logic [15:0] tmr_cnt_r;
    logic tmr_ck_q, tmr_tick, tmr_expired_r;

    // ---------------------------------------------------------------
    // hardware reset recognition
    // ---------------------------------------------------------------
    // a pulse shorter than the least width is not taken as reset
    always_ff @(posedge clk) begin
        if (rst || hw_reset_in_n) begin
            hw_low_cnt_r <= 2'd0;
        end else if (hw_low_cnt_r != 2'(`OUH_HWRST_CYC)) begin
            hw_low_cnt_r <= hw_low_cnt_r + 2'd1;
        end
    end
    assign hw_rst = !hw_reset_in_n && (hw_low_cnt_r == 2'(`OUH_HWRST_CYC) - 2'd1 ||
                    hw_low_cnt_r == 2'(`OUH_HWRST_CYC));
    assign core_rst = rst || hw_rst;

    // ---------------------------------------------------------------
    // bus style decode
    // ---------------------------------------------------------------
    // style two: chip select is the strobe and write strobe pin is read/write
    always_comb begin
        if (bus_style_strap) begin
            rd_act = !chip_select_n && !read_strobe_n;
            wr_act = !chip_select_n && !write_strobe_n;
        end else begin
            rd_act = !chip_select_n && write_strobe_n;
            wr_act = !chip_select_n && !write_strobe_n;
        end
    end

    // access phase; a held strobe is one access only
    always_comb begin
        case ({wr_act, rd_act})
            2'b10: acc_nxt = OUH_ACC_WR;
            2'b01: acc_nxt = OUH_ACC_RD;
            default: acc_nxt = OUH_ACC_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (core_rst) begin
            acc_r <= OUH_ACC_IDLE;
        end else begin
            acc_r <= acc_nxt;
        end
    end
    assign wr_pulse = (acc_nxt == OUH_ACC_WR) && (acc_r != OUH_ACC_WR);
    assign rd_pulse = (acc_nxt == OUH_ACC_RD) && (acc_r != OUH_ACC_RD);

    // ---------------------------------------------------------------
    // channel routing
    // ---------------------------------------------------------------
    assign cfg_sel = addr[7];
    assign chan_sel = addr[6:4];
    // broadcast overrides the decoded channel on writes only
    assign chan_we = (!wr_pulse || cfg_sel) ? 8'h00 :
                     bcast_r[`OUH_BCAST_BIT] ? 8'hff : (8'h01 << chan_sel);

    generate
        for (genvar g = 0; g < `OUH_NCH; g++) begin : g_chan
            ouh_chan_regs u_chan (
                .clk(clk),
                .rst(core_rst),
                .soft_rst(soft_rst_r[g]),
                .infrared_startup_strap(infrared_startup_strap),
                .wr_en(chan_we[g]),
                .addr(addr[3:0]),
                .wdata(data_in),
                .rd_data(chan_rd[g]),
                .serial_receive_in(serial_receive_in[g]),
                .clear_send_in_n(clear_send_in_n[g]),
                .set_ready_in_n(set_ready_in_n[g]),
                .carrier_detect_in_n(carrier_detect_in_n[g]),
                .ring_indicate_in_n(ring_indicate_in_n[g]),
                .request_send_out_n(request_send_out_n[g]),
                .terminal_ready_out_n(terminal_ready_out_n[g]),
                .ir_decoder_in_r(ir_decoder_in_r[g]),
                .rx_idle_r(rx_idle_r[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // config space registers
    // ---------------------------------------------------------------
    // soft reset bits are one-cycle pulses, never stored
    always_ff @(posedge clk) begin
        if (core_rst) begin
            soft_rst_r <= 8'h00;
        end else if (wr_pulse && cfg_sel && addr[6:0] == `OUH_CFG_SWRST) begin
            soft_rst_r <= data_in;
        end else begin
            soft_rst_r <= 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            bcast_r <= `OUH_REG_RST_VAL;
            tmr_ctrl_r <= `OUH_REG_RST_VAL;
            tmr_lsb_r <= `OUH_REG_RST_VAL;
            tmr_msb_r <= `OUH_REG_RST_VAL;
        end else if (wr_pulse && cfg_sel) begin
            case (addr[6:0])
                `OUH_CFG_BCAST: bcast_r <= data_in;
                `OUH_CFG_TMR_CTRL: tmr_ctrl_r <= data_in;
                `OUH_CFG_TMR_LSB: tmr_lsb_r <= data_in;
                `OUH_CFG_TMR_MSB: tmr_msb_r <= data_in;
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // timer/counter
    // ---------------------------------------------------------------
    // external clock is sampled, so it must stay below half of clk
    always_ff @(posedge clk) begin
        if (core_rst) begin
            tmr_ck_q <= 1'b0;
        end else begin
            tmr_ck_q <= timer_ext_clock;
        end
    end
    assign tmr_tick = tmr_ctrl_r[`OUH_TMR_EN_BIT] &&
                      (!tmr_ctrl_r[`OUH_TMR_EXT_BIT] || (timer_ext_clock && !tmr_ck_q));

    // writing control reloads; expiry flag set wins over its read clear
    always_ff @(posedge clk) begin
        if (core_rst) begin
            tmr_cnt_r <= 16'h0000;
            tmr_expired_r <= 1'b0;
        end else begin
            if (wr_pulse && cfg_sel && addr[6:0] == `OUH_CFG_TMR_CTRL) begin
                tmr_cnt_r <= {tmr_msb_r, tmr_lsb_r};
            end else if (tmr_tick) begin
                tmr_cnt_r <= (tmr_cnt_r == 16'h0000) ? {tmr_msb_r, tmr_lsb_r} : tmr_cnt_r - 16'h0001;
            end
            if (tmr_tick && tmr_cnt_r == 16'h0000) begin
                tmr_expired_r <= 1'b1;
            end else if (rd_pulse && cfg_sel && addr[6:0] == `OUH_CFG_INT1) begin
                tmr_expired_r <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    always_comb begin
        int1 = 8'h00;
        int1[`OUH_INT1_TMR_BIT] = tmr_expired_r;
        int1[`OUH_INT1_WAKE_BIT] = wake_in;
        case (addr[6:0])
            `OUH_CFG_INT0: cfg_rd = chan_irq_in;
            `OUH_CFG_INT1: cfg_rd = int1;
            `OUH_CFG_INT2: cfg_rd = 8'h00;
            `OUH_CFG_INT3: cfg_rd = 8'h00;
            `OUH_CFG_TMR_CTRL: cfg_rd = tmr_ctrl_r;
            `OUH_CFG_TMR_LSB: cfg_rd = tmr_cnt_r[7:0];
            `OUH_CFG_TMR_MSB: cfg_rd = tmr_cnt_r[15:8];
            `OUH_CFG_BCAST: cfg_rd = bcast_r;
            default: cfg_rd = 8'h00;
        endcase
    end

    // data follows the bus while read is held; bus driven one cycle later
    always_ff @(posedge clk) begin
        if (core_rst) begin
            data_out_r <= 8'h00;
        end else if (acc_nxt == OUH_ACC_RD) begin
            data_out_r <= cfg_sel ? cfg_rd : chan_rd[chan_sel];
        end
    end
    assign data_out_en_n = (acc_r != OUH_ACC_RD);

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    cs_gate_a: assert property (@(posedge clk) disable iff (core_rst)
        chip_select_n |-> (chan_we == 8'h00 && !rd_pulse) ##1 soft_rst_r == 8'h00)
        else $error("access taken without chip select");
    chan_decode_a: assert property (@(posedge clk) disable iff (core_rst)
        wr_pulse && !addr[7] && !bcast_r[0] |-> chan_we == (8'h01 << addr[6:4]))
        else $error("channel decode wrong");
    bcast_all_a: assert property (@(posedge clk) disable iff (core_rst)
        wr_pulse && !addr[7] && bcast_r[0] |-> chan_we == 8'hff)
        else $error("broadcast write missed a channel");
    cfg_route_a: assert property (@(posedge clk) disable iff (core_rst)
        addr[7] |-> chan_we == 8'h00)
        else $error("config access reached a channel");
    style_two_a: assert property (@(posedge clk) disable iff (core_rst)
        !bus_style_strap && !chip_select_n |-> wr_act == !write_strobe_n && rd_act == write_strobe_n)
        else $error("second bus style decode wrong");
    soft_reset_a: assert property (@(posedge clk) disable iff (core_rst)
        wr_pulse && addr == 8'h8a && data_in[2] |=> soft_rst_r[2] ##1 request_send_out_n[2])
        else $error("soft reset did not reach channel");
    hw_reset_a: assert property (@(posedge clk) disable iff (rst)
        !hw_reset_in_n [*2] |=> request_send_out_n == 8'hff && terminal_ready_out_n == 8'hff)
        else $error("hardware reset left modem pins active");
    timer_step_a: assert property (@(posedge clk) disable iff (core_rst)
        tmr_tick && tmr_cnt_r != 16'h0000 && !wr_pulse |=> tmr_cnt_r == $past(tmr_cnt_r) - 16'h0001)
        else $error("timer did not count down");
    int_src_a: assert property (@(posedge clk) disable iff (core_rst)
        acc_nxt == OUH_ACC_RD && addr == 8'h80 |=> data_out_r == $past(chan_irq_in))
        else $error("interrupt source read wrong");

    bcast_write_c: cover property (@(posedge clk) disable iff (core_rst) wr_pulse && chan_we == 8'hff);
    style_two_read_c: cover property (@(posedge clk) disable iff (core_rst) !bus_style_strap && rd_pulse);
    soft_reset_c: cover property (@(posedge clk) disable iff (core_rst) soft_rst_r != 8'h00);
    timer_expire_c: cover property (@(posedge clk) disable iff (core_rst) tmr_expired_r);
endmodule // ouh_top
`default_nettype wire

// File: sim/ouh_host_model.sv
// Purpose: host cpu model driving the parallel host port
// Assumes: design samples its inputs on the rising clk edge
// Notes: idle address and data lines show the inverted last value
`timescale 1ns/1ns
`default_nettype none
module ouh_host_model (
    // clock and strap
    input wire logic clk,
    input wire logic bus_style_strap,
    // host bus
    output logic chip_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [7:0] addr,
    output ouh_pkg::ouh_byte_t data_in,
    input wire ouh_pkg::ouh_byte_t data_out_r,
    input wire logic data_out_en_n
);
    import ouh_pkg::*;
    // ---------------------------------------------------------------
    // bus cycles
    // ---------------------------------------------------------------
    // quiet bus until the first access
    initial begin
        chip_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        addr = 8'h00;
        data_in = 8'h00;
    end
    // one access; the leading edge wait leaves an idle cycle between accesses
    task automatic access(input logic sel, input logic wr, input logic [7:0] a, input ouh_byte_t d,
                          output ouh_byte_t q, output logic en_n);
        @(posedge clk);
        #1;
        chip_select_n = ~sel;
        write_strobe_n = ~wr;
        read_strobe_n = ~(bus_style_strap & ~wr);
        addr = a;
        data_in = d;
        @(posedge clk);
        #1;
        // read data is launched at this edge and can change at the next one, so take it settled here
        q = data_out_r;
        en_n = data_out_en_n;
        if (!wr) begin
            @(posedge clk);
            #1;
        end
        // flipped idle lines so a stale value never looks valid
        chip_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        addr = ~addr;
        data_in = ~data_in;
    endtask
endmodule // ouh_host_model
`default_nettype wire

// File: sim/ouh_top_tb_top.sv
// Purpose: self-checking bench of the octal uart host front end
// Assumes: host model speaks both strap styles
// Notes: random data from a fixed seed, corner cases by hand
`include "ouh_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module ouh_top_tb_top;
    import ouh_pkg::*;
    logic clk, rst, hw_reset_in_n, bus_style_strap, infrared_startup_strap;
    logic chip_select_n, read_strobe_n, write_strobe_n, data_out_en_n, wake_in, timer_ext_clock;
    logic [7:0] addr, chan_irq_in, serial_receive_in, clear_send_in_n, set_ready_in_n;
    logic [7:0] carrier_detect_in_n, ring_indicate_in_n, request_send_out_n, terminal_ready_out_n;
    logic [7:0] ir_decoder_in_r, rx_idle_r;
    ouh_byte_t data_in, data_out_r;
    int fails, num_checks, cycles;
    ouh_top uut (.clk(clk), .rst(rst), .hw_reset_in_n(hw_reset_in_n), .bus_style_strap(bus_style_strap),
        .infrared_startup_strap(infrared_startup_strap), .chip_select_n(chip_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .addr(addr), .data_in(data_in),
        .data_out_r(data_out_r), .data_out_en_n(data_out_en_n), .chan_irq_in(chan_irq_in), .wake_in(wake_in),
        .timer_ext_clock(timer_ext_clock), .serial_receive_in(serial_receive_in),
        .clear_send_in_n(clear_send_in_n), .set_ready_in_n(set_ready_in_n),
        .carrier_detect_in_n(carrier_detect_in_n), .ring_indicate_in_n(ring_indicate_in_n),
        .request_send_out_n(request_send_out_n), .terminal_ready_out_n(terminal_ready_out_n),
        .ir_decoder_in_r(ir_decoder_in_r), .rx_idle_r(rx_idle_r));
    ouh_host_model host (.clk(clk), .bus_style_strap(bus_style_strap), .chip_select_n(chip_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .addr(addr), .data_in(data_in),
        .data_out_r(data_out_r), .data_out_en_n(data_out_en_n));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask
    task automatic complete_run();
        if (fails == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] cha(input int ch, input logic [3:0] r);
        return {1'b0, ch[2:0], r};
    endfunction
    function automatic logic [7:0] msr_exp(input int ch);
        return {~carrier_detect_in_n[ch], ~ring_indicate_in_n[ch], ~set_ready_in_n[ch], ~clear_send_in_n[ch], 4'h0};
    endfunction
    task automatic wr(input logic [7:0] a, input ouh_byte_t d);
        ouh_byte_t q;
        logic e;
        host.access(1'b1, 1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, output ouh_byte_t q);
        logic e;
        host.access(1'b1, 1'b0, a, 8'h00, q, e);
        chk("read enable", 8'h00, {7'h0, e});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // ---------------------------------------------------------------
    // clock, watchdog, main sequence
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // a hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        ouh_byte_t q, v0, m;
        ouh_byte_t v[8];
        logic [7:0] rts, dtr;
        logic e;
        void'($urandom(32'h6736));
        {rst, hw_reset_in_n, bus_style_strap, infrared_startup_strap} = 4'b1111;
        {chan_irq_in, wake_in, timer_ext_clock} = 10'h0;
        {serial_receive_in, clear_send_in_n, set_ready_in_n} = {24{1'b1}};
        {carrier_detect_in_n, ring_indicate_in_n} = 16'hffff;
        cyc(2);
        rst = 1'b0;
        chk("rts after reset", 8'hff, request_send_out_n);
        chk("dtr after reset", 8'hff, terminal_ready_out_n);
        for (int ch = 0; ch < 8; ch++) begin
            rd(cha(ch, `OUH_CH_MCR), q);
            chk("mcr strap", 8'h40, q);
        end
        // decode in both bus styles, unselected and config cycles must not land
        for (int st = 1; st >= 0; st--) begin
            bus_style_strap = st[0];
            for (int ch = 0; ch < 8; ch++) begin
                v[ch] = 8'($urandom);
                wr(cha(ch, 4'h7), v[ch]);
                host.access(1'b0, 1'b1, cha(ch, 4'h7), ~v[ch], q, e);
            end
            wr(8'h87, 8'h00);
            host.access(1'b0, 1'b0, cha(0, 4'h7), 8'h00, q, e);
            chk("unselected enable", 8'h01, {7'h0, e});
            for (int ch = 0; ch < 8; ch++) begin
                rd(cha(ch, 4'h7), q);
                chk("channel scratch", v[ch], q);
            end
        end
        // broadcast, taken while all channels are idle
        v0 = 8'($urandom);
        wr(8'h8f, 8'h01);
        wr(cha(3, 4'h7), v0);
        wr(8'h8f, 8'h00);
        rts = 8'h00;
        dtr = 8'h00;
        for (int ch = 0; ch < 8; ch++) begin
            rd(cha(ch, 4'h7), q);
            chk("broadcast scratch", v0, q);
            m = {6'h10, 2'($urandom)};
            wr(cha(ch, `OUH_CH_MCR), m);
            rts[ch] = ~m[1];
            dtr[ch] = ~m[0];
        end
        chk("rts pins", rts, request_send_out_n);
        chk("dtr pins", dtr, terminal_ready_out_n);
        {clear_send_in_n, set_ready_in_n, carrier_detect_in_n, ring_indicate_in_n} = $urandom;
        for (int ch = 0; ch < 8; ch++) begin
            rd(cha(ch, `OUH_CH_MSR), q);
            chk("modem status", msr_exp(ch), {q[7:4], 4'h0});
        end
        // infrared front end, inverted then plain
        wr(8'h8f, 8'h01);
        wr(cha(0, `OUH_CH_FEATURE_CONTROL_REG), 8'h10);
        wr(8'h8f, 8'h00);
        serial_receive_in = 8'($urandom);
        cyc(2);
        chk("ir inverted", ~serial_receive_in, ir_decoder_in_r);
        wr(8'h8f, 8'h01);
        wr(cha(0, `OUH_CH_FEATURE_CONTROL_REG), 8'h00);
        wr(8'h8f, 8'h00);
        cyc(1);
        chk("ir plain", serial_receive_in, ir_decoder_in_r);
        infrared_startup_strap = 1'b0;
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        rd(cha(5, `OUH_CH_MCR), q);
        chk("mcr strap low", 8'h00, q);
        serial_receive_in = 8'($urandom);
        cyc(2);
        chk("rx idle", serial_receive_in, rx_idle_r);
        // soft reset of channel 2 only, strap raised meanwhile
        wr(cha(2, `OUH_CH_MCR), 8'h03);
        wr(cha(3, `OUH_CH_MCR), 8'h03);
        infrared_startup_strap = 1'b1;
        wr(8'h8a, 8'h04);
        cyc(3);
        rd(cha(2, `OUH_CH_MCR), q);
        chk("soft reset mcr", 8'h40, q);
        rd(cha(3, `OUH_CH_MCR), q);
        chk("spared mcr", 8'h03, q);
        // hardware reset pin, held past the minimum width
        hw_reset_in_n = 1'b0;
        cyc(3);
        hw_reset_in_n = 1'b1;
        cyc(1);
        chk("rts after pin reset", 8'hff, request_send_out_n);
        rd(cha(3, `OUH_CH_MCR), q);
        chk("mcr after pin reset", 8'h40, q);
        // interrupt source registers
        chan_irq_in = 8'($urandom);
        wake_in = 1'b1;
        cyc(1);
        rd(8'h80, q);
        chk("int0", chan_irq_in, q);
        rd(8'h81, q);
        chk("int1 wake", 8'h02, q & 8'h02);
        rd(8'h82, q);
        chk("int2", 8'h00, q);
        rd(8'h83, q);
        chk("int3", 8'h00, q);
        // timer on the external clock
        wr(8'h86, 8'h03);
        wr(8'h87, 8'h00);
        wr(8'h84, 8'h03);
        rd(8'h81, q);
        chk("timer idle", 8'h00, q & 8'h01);
        repeat (6) begin
            timer_ext_clock = 1'b1;
            cyc(3);
            timer_ext_clock = 1'b0;
            cyc(3);
        end
        rd(8'h81, q);
        chk("timer expired", 8'h01, q & 8'h01);
        rd(8'h81, q);
        chk("timer cleared", 8'h00, q & 8'h01);
        complete_run();
    end
endmodule // ouh_top_tb_top
`default_nettype wire
